// ### verilog/capture_compare_module.v
// Purpose: one capture/compare module of a counter array
// Assumes: shared 16-bit counter and timebase tick come from outside
// Notes:   modes are capture, timer, toggle, frequency, PWM8, PWM16
//
// Notes on behaviour
// - Qualifying pin edge in capture mode copies counter into compare word.
// - Rise and fall enables pick rising, falling, or either edge.
// - Capture sets event flag; interrupt requested when enabled.
// - Event flag is cleared only by software write, never by hardware.
// - Timer mode: counter equal to compare word sets event flag.
// - Low byte write clears compare enable; high byte write sets it.
// - High-speed output mode inverts the pin on each 16-bit match.
// - Entering high-speed output mode sets toggle output to one.
// - Frequency mode: low byte match toggles pin, adds high to low.
// - Frequency mode: high byte zero gives half-period of 256 counts.
// - PWM8: pin goes high when counter low byte equals compare low.
// - PWM8: pin goes low when counter low byte overflows.
// - PWM8: low byte rollover reloads compare low from compare high.
// - PWM enable with toggle and wide clear and no edge bits selects PWM8.
// - PWM8 with compare high zero gives continuous high output.
// - Compare enable clear in PWM mode holds output low.
// - PWM16: high on full 16-bit match, low on counter overflow.
// - PWM enable and wide select, with toggle and edge bits clear, choose PWM16.
// - PWM16 compare 0xffff gives one-count high time per period.
// - Capture needs match, toggle, PWM clear and an edge bit set.
// - Shared counter overflows when wrapping from 0xffff to 0x0000.
// - Event interrupt enable gates the flag onto the interrupt request.
`timescale 1ns/100ps
`include "cc_module_defines.vh"

module capture_compare_module (
   // Clock and reset
   input  wire        clk,
   input  wire        reset_n,
   // Shared counter
   input  wire [15:0] countValue,
   input  wire        countTick,
   // Software register writes
   input  wire        modeWrite,
   input  wire [7:0]  modeWriteData,
   input  wire        lowWrite,
   input  wire        highWrite,
   input  wire [7:0]  byteWriteData,
   input  wire        flagWrite,
   input  wire        flagWriteData,
   // Register read-back
   output wire [7:0]  moduleModeReg,
   output wire [7:0]  compareLowByte,
   output wire [7:0]  compareHighByte,
   output wire        moduleEventFlag,
   output wire        eventIrq,
   // Module pin
   input  wire        moduleIoPinIn,
   output wire        moduleIoPinOut,
   output wire        moduleIoPinOe_n
);

   ////////////////////////////////////////////////////////////////////////
   reg  [7:0]  modeBits;
   reg  [7:0]  cmpLow;
   reg  [7:0]  cmpHigh;
   reg         eventFlag;
   reg         pinOut;
   reg         pinSync1;
   reg         pinSync2;
   reg         pinPrev;
   reg         wasHighSpeed;
   reg  [7:0]  next_cmpLow;
   reg         next_pinOut;
   reg         next_event;

   wire        compareEn  = modeBits[`MODE_CMP_EN_BIT];
   wire        matchEn    = modeBits[`MODE_MATCH_BIT];
   wire        toggleEn   = modeBits[`MODE_TOGGLE_BIT];
   wire        pwmEn      = modeBits[`MODE_PWM_EN_BIT];
   wire        widePwm    = modeBits[`MODE_WIDE_PWM_BIT];
   wire        riseEn     = modeBits[`MODE_RISE_BIT];
   wire        fallEn     = modeBits[`MODE_FALL_BIT];
   wire        irqEn      = modeBits[`MODE_IRQ_EN_BIT];

   ////////////////////////////////////////////////////////////////////////
   // Mode decode
   wire captureMode = ~matchEn & ~toggleEn & ~pwmEn & (riseEn | fallEn);
   wire anyCapBits  = riseEn | fallEn;
   wire timerMode   = ~anyCapBits & compareEn & matchEn & ~toggleEn
                      & ~pwmEn;
   wire hsoMode     = ~anyCapBits & compareEn & matchEn & toggleEn
                      & ~pwmEn;
   wire freqMode    = ~anyCapBits & compareEn & toggleEn & pwmEn;
   wire pwmSel      = ~anyCapBits & ~toggleEn & pwmEn;
   wire pwm8Mode    = pwmSel & ~widePwm;
   wire pwm16Mode   = pwmSel & widePwm;

   // Edge detection on synchronised samples
   wire riseEdge = pinSync2 & ~pinPrev;
   wire fallEdge = ~pinSync2 & pinPrev;
   wire captureHit = captureMode &
                     ((riseEn & riseEdge) | (fallEn & fallEdge));

   // Counter events gated by the timebase tick
   wire [15:0] countNext = countValue + 16'h0001;
   wire fullMatch = countTick & (countValue == {cmpHigh, cmpLow});
   wire lowMatch  = countTick & (countValue[7:0] == cmpLow);
   wire lowOvf    = countTick & (countValue[7:0] == `LOW_MAX);
   wire fullOvf   = countTick & (countValue == `COUNT_MAX);

   // PWM edges look at the count being entered, so that the high time
   // covers the compare count itself
   wire pwm8Match  = countTick & (countNext[7:0] == cmpLow);
   // A compare of 0xffff is entered on the last count: one count high
   wire pwm16Match = countTick & (countNext == {cmpHigh, cmpLow});

   // Frequency step, carry dropped so the offset wraps mod 256
   wire [8:0] lowSum = {1'b0, cmpLow} + {1'b0, cmpHigh};

   ////////////////////////////////////////////////////////////////////////
   // Pin synchroniser
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pinSync1 <= 1'b0;
         pinSync2 <= 1'b0;
         pinPrev  <= 1'b0;
      end else begin
         pinSync1 <= moduleIoPinIn;
         pinSync2 <= pinSync1;
         pinPrev  <= pinSync2;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Active mode as a binary code
   localparam [2:0] MODE_IDLE    = 3'h0;
   localparam [2:0] MODE_CAPTURE = 3'h1;
   localparam [2:0] MODE_TIMER   = 3'h2;
   localparam [2:0] MODE_HSO     = 3'h3;
   localparam [2:0] MODE_FREQ    = 3'h4;
   localparam [2:0] MODE_PWM8    = 3'h5;
   localparam [2:0] MODE_PWM16   = 3'h6;

   reg  [2:0]  modeCode;
   reg         pinOe_n;

   // The decodes above are exclusive, so the chain order is free
   always @* begin
      if (captureMode) begin
         modeCode = MODE_CAPTURE;
      end else if (timerMode) begin
         modeCode = MODE_TIMER;
      end else if (hsoMode) begin
         modeCode = MODE_HSO;
      end else if (freqMode) begin
         modeCode = MODE_FREQ;
      end else if (pwm8Mode) begin
         modeCode = MODE_PWM8;
      end else if (pwm16Mode) begin
         modeCode = MODE_PWM16;
      end else begin
         modeCode = MODE_IDLE;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin drive next value
   always @* begin
      next_pinOut = pinOut;
      case (modeCode)
         MODE_HSO: begin
            if (!wasHighSpeed) begin
               next_pinOut = 1'b1;
            end else if (fullMatch) begin
               next_pinOut = ~pinOut;
            end
         end
         MODE_FREQ: begin
            if (lowMatch) begin
               next_pinOut = ~pinOut;
            end
         end
         MODE_PWM8: begin
            if (!compareEn) begin
               next_pinOut = 1'b0;
            end else if (lowOvf) begin
               // A reloaded zero is entered at once: pin stays high
               next_pinOut = (cmpHigh == 8'h00);
            end else if (pwm8Match) begin
               next_pinOut = 1'b1;
            end
         end
         MODE_PWM16: begin
            if (!compareEn) begin
               next_pinOut = 1'b0;
            end else if (pwm16Match) begin
               next_pinOut = 1'b1;
            end else if (fullOvf) begin
               next_pinOut = 1'b0;
            end
         end
         default: begin
            next_pinOut = pinOut;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Event flag set request
   always @* begin
      next_event = 1'b0;
      case (modeCode)
         MODE_CAPTURE: begin
            next_event = captureHit;
         end
         MODE_TIMER: begin
            next_event = fullMatch;
         end
         MODE_HSO: begin
            next_event = wasHighSpeed & fullMatch;
         end
         MODE_FREQ: begin
            next_event = matchEn & lowMatch;
         end
         MODE_PWM8: begin
            next_event = matchEn & compareEn & ~lowOvf & pwm8Match;
         end
         MODE_PWM16: begin
            next_event = matchEn & compareEn & pwm16Match;
         end
         default: begin
            next_event = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Compare low byte hardware update
   always @* begin
      next_cmpLow = cmpLow;
      if (freqMode && lowMatch) begin
         // Wraps mod 256, so a zero offset gives 256 counts
         next_cmpLow = lowSum[7:0];
      end else if (pwm8Mode && compareEn && lowOvf) begin
         next_cmpLow = cmpHigh;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin output enable, low while the module drives the pin
   always @* begin
      case (modeCode)
         MODE_HSO: begin
            pinOe_n = 1'b0;
         end
         MODE_FREQ: begin
            pinOe_n = 1'b0;
         end
         MODE_PWM8: begin
            pinOe_n = 1'b0;
         end
         MODE_PWM16: begin
            pinOe_n = 1'b0;
         end
         default: begin
            // Released in capture, timer and idle
            pinOe_n = 1'b1;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Mode register
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         modeBits <= `MODE_RESET;
      end else begin
         // A full mode write beats the byte-write side effect
         if (modeWrite) begin
            modeBits <= modeWriteData;
         end else if (lowWrite) begin
            modeBits[`MODE_CMP_EN_BIT] <= 1'b0;
         end else if (highWrite) begin
            modeBits[`MODE_CMP_EN_BIT] <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Compare bytes
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cmpLow  <= `CMP_RESET;
         cmpHigh <= `CMP_RESET;
      end else begin
         // A capture takes precedence over software byte writes
         if (captureHit) begin
            cmpLow  <= countValue[7:0];
            cmpHigh <= countValue[15:8];
         end else begin
            if (lowWrite) begin
               cmpLow <= byteWriteData;
            end else begin
               cmpLow <= next_cmpLow;
            end
            if (highWrite) begin
               cmpHigh <= byteWriteData;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Event flag
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         eventFlag <= 1'b0;
      end else begin
         // Hardware set wins over a software clear in the same cycle
         if (next_event) begin
            eventFlag <= 1'b1;
         end else if (flagWrite) begin
            eventFlag <= flagWriteData;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin drive and mode entry tracking
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pinOut       <= `PIN_RESET;
         wasHighSpeed <= 1'b0;
      end else begin
         wasHighSpeed <= hsoMode;
         pinOut       <= next_pinOut;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign moduleModeReg   = modeBits;
   assign compareLowByte  = cmpLow;
   assign compareHighByte = cmpHigh;
   assign moduleEventFlag = eventFlag;
   assign eventIrq        = eventFlag & irqEn;
   assign moduleIoPinOut  = pinOut;
   assign moduleIoPinOe_n = pinOe_n;

endmodule // capture_compare_module

// ### verilog/cc_module_defines.vh
// Purpose: constants for one counter array capture/compare module
// Assumes: 8-bit byte writes from the system controller
// Notes:   mode register bit positions and reset values
`ifndef CC_MODULE_DEFINES_VH
`define CC_MODULE_DEFINES_VH

// Mode register bit positions
`define MODE_IRQ_EN_BIT    0
`define MODE_PWM_EN_BIT    1
`define MODE_TOGGLE_BIT    2
`define MODE_MATCH_BIT     3
`define MODE_FALL_BIT      4
`define MODE_RISE_BIT      5
`define MODE_CMP_EN_BIT    6
`define MODE_WIDE_PWM_BIT  7

// Reset values
`define MODE_RESET         8'h00
`define CMP_RESET          8'h00
`define PIN_RESET          1'b0

// Counter limits
`define COUNT_MAX          16'hffff
`define LOW_MAX            8'hff

`endif

// ### verif/cc_module_checker.sv
// Purpose: assertions on one capture/compare module
// Assumes: a tick shows the count being left
// Notes:   bound by name to the module
`timescale 1ns/100ps
module cc_module_checker (
   // Clock, reset and counter
   input wire        clk,
   input wire        reset_n,
   input wire [15:0] countValue,
   input wire        countTick,
   // Writes
   input wire        modeWrite,
   input wire        lowWrite,
   input wire        highWrite,
   input wire        flagWrite,
   // Outputs
   input wire [7:0]  moduleModeReg,
   input wire [7:0]  compareLowByte,
   input wire [7:0]  compareHighByte,
   input wire        moduleEventFlag,
   input wire        eventIrq,
   input wire        moduleIoPinOut
);
   wire [7:0] md   = moduleModeReg;
   wire       hit  = countTick && !modeWrite && !lowWrite && !highWrite;
   wire       eq   = countValue == {compareHighByte, compareLowByte};
   wire       eqLo = countValue[7:0] == compareLowByte;
   wire       eqN  = countValue + 16'h1 == {compareHighByte, compareLowByte};
   wire       top  = countValue == 16'hffff;
   wire       cmp  = md[6] && md[5:4] == 2'h0;
   wire       pwm  = cmp && md[2:1] == 2'h1;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   AST_EN: assert property ((lowWrite ^ highWrite) && !modeWrite
      |=> md[6] == $past(highWrite)) else $error("compare enable wrong");
   AST_IRQ: assert property (eventIrq == (moduleEventFlag && md[0]))
      else $error("interrupt request wrong");
   AST_STICKY: assert property (moduleEventFlag && !flagWrite
      |=> moduleEventFlag) else $error("flag cleared by hardware");
   AST_TIMER: assert property (hit && cmp && md[3:1] == 3'h4 && eq
      |=> moduleEventFlag) else $error("timer match missed");
   AST_HSO: assert property (hit && cmp && md[3:1] == 3'h6 && eq
      && $stable(md) |=> moduleIoPinOut != $past(moduleIoPinOut))
      else $error("pin not toggled on match");
   AST_FREQ: assert property (hit && cmp && md[2:1] == 2'h3 && eqLo
      |=> compareLowByte == 8'($past(compareLowByte) + $past(compareHighByte))
      && moduleIoPinOut != $past(moduleIoPinOut)) else $error("freq step");
   AST_PWM8_WRAP: assert property (hit && pwm && !md[7]
      && countValue[7:0] == 8'hff |=> compareLowByte == $past(compareHighByte)
      && moduleIoPinOut == ($past(compareHighByte) == 8'h00))
      else $error("low byte wrap wrong");
   AST_PWM16: assert property (hit && pwm && md[7] && (eqN || top)
      |=> moduleIoPinOut == $past(eqN)) else $error("wide pwm edge wrong");
   cover property (hit && cmp && md[3:1] == 3'h4 && eq);
   cover property (hit && pwm && !md[7] && countValue[7:0] == 8'hff);
   cover property (hit && pwm && md[7] && eq);
endmodule // cc_module_checker

bind capture_compare_module cc_module_checker chk_u (.clk, .reset_n,
   .countValue, .countTick, .modeWrite, .lowWrite, .highWrite, .flagWrite,
   .moduleModeReg, .compareLowByte, .compareHighByte, .moduleEventFlag,
   .eventIrq, .moduleIoPinOut);

// ### verif/pin_source.sv
// Purpose: external source on the module pin
// Assumes: one system clock
// Notes:   a level is never shorter than two clocks
`timescale 1ns/100ps
module pin_source (
   // Clock and request
   input  wire       clk,
   input  wire       wantLevel,
   // Pin
   output reg        pinLevel = 1'b0
);
   reg [1:0] age = 2'h0;
   always @(posedge clk) begin
      if (wantLevel != pinLevel && age >= 2'h2) begin
         pinLevel <= wantLevel;
         age      <= 2'h1;
      end else if (age != 2'h3) begin
         age <= age + 2'h1;
      end
   end
endmodule // pin_source

// ### verif/tb_top.sv
// Purpose: self-checking bench for the capture/compare module
// Assumes: bench plays the shared counter and software
// Notes:   flag events are matched against a queue of expected words
`timescale 1ns/100ps
module tb_top;
   reg          clk, reset_n, countTick, modeWrite, lowWrite, highWrite;
   reg          flagWrite, flagWriteData, wantLevel, q, last;
   reg  [15:0]  countValue, cv;
   reg  [7:0]   modeWriteData, byteWriteData;
   wire [7:0]   moduleModeReg, compareLowByte, compareHighByte;
   wire         moduleEventFlag, eventIrq, moduleIoPinIn, moduleIoPinOut;
   wire         moduleIoPinOe_n;
   logic [15:0] expQ [$];
   logic [31:0] seed = 32'd41162;
   logic [7:0]  hs [3] = '{8'h00, 8'h80, 8'hff};
   int          bad_count = 0, checked = 0, hi, tg, i, k;
   capture_compare_module dut_u (.clk, .reset_n, .countValue, .countTick,
      .modeWrite, .modeWriteData, .lowWrite, .highWrite, .byteWriteData,
      .flagWrite, .flagWriteData, .moduleModeReg, .compareLowByte,
      .compareHighByte, .moduleEventFlag, .eventIrq, .moduleIoPinIn,
      .moduleIoPinOut, .moduleIoPinOe_n);
   pin_source src_u (.clk, .wantLevel, .pinLevel(moduleIoPinIn));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[15:0];
   endfunction
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      checked++;
      if (s !== e) begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic wr(input int kind, input logic [7:0] d);
      @(posedge clk);
      modeWrite     <= kind == 0;
      lowWrite      <= kind == 1;
      highWrite     <= kind == 2;
      flagWrite     <= kind == 3;
      modeWriteData <= d;
      byteWriteData <= d;
      @(posedge clk);
      {modeWrite, lowWrite, highWrite, flagWrite} <= 4'h0;
      @(negedge clk);
   endtask
   task automatic cfg(input logic [7:0] m, input logic [15:0] w);
      wr(0, m);
      wr(1, w[7:0]);
      wr(2, w[15:8]);
   endtask
   // Ticks every cycle, counting high samples and pin transitions
   task automatic run(input int n, input logic [15:0] s, input bit load);
      @(posedge clk);
      if (load) countValue <= s;
      countTick <= 1'b1;
      {hi, tg} = 0;
      last = moduleIoPinOut;
      for (int j = 1; j <= n; j++) begin
         @(posedge clk);
         countValue <= countValue + 16'h1;
         countTick  <= j < n;
         @(negedge clk);
         hi += moduleIoPinOut;
         tg += moduleIoPinOut != last;
         last = moduleIoPinOut;
      end
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      end_sim();
   end
   always @(posedge moduleEventFlag) begin
      #1;
      cv = {compareHighByte, compareLowByte};
      chk(cv, expQ.size() ? expQ.pop_front() : ~cv);
   end
   initial begin
      {reset_n, countTick, modeWrite, lowWrite, highWrite} = 5'h0;
      {flagWrite, flagWriteData, wantLevel} = 3'h0;
      {countValue, modeWriteData, byteWriteData} = 32'h0;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      @(negedge clk);
      chk({moduleModeReg, compareLowByte}, 16'h0);
      chk({compareHighByte, 4'h0, eventIrq, moduleEventFlag,
         moduleIoPinOut, moduleIoPinOe_n}, 16'h1);
      wr(1, 8'h34);
      chk({moduleModeReg, compareLowByte}, 16'h0034);
      wr(2, 8'h12);
      chk({moduleModeReg, compareHighByte}, 16'h4012);
      for (k = 1; k < 4; k++) begin
         wr(0, {2'h0, k[0], k[1], 4'h1});
         for (i = 0; i < 4; i++) begin
            cv = rnd();
            q = i[0] ? k[1] : k[0];
            @(posedge clk);
            countValue <= cv;
            wantLevel  <= !wantLevel;
            if (q) expQ.push_back(cv);
            repeat (8) @(negedge clk);
            chk({15'h0, moduleEventFlag}, {15'h0, q});
            wr(3, 8'h00);
         end
      end
      for (k = 0; k < 2; k++) begin
         cv = rnd();
         cfg(k ? 8'h0c : 8'h09, cv);
         expQ.push_back(cv);
         @(negedge clk);
         if (k) chk({15'h0, moduleIoPinOut}, 16'h1);
         run(8, cv - 16'h4, 1);
         if (k) chk(tg[15:0], 16'h1);
         wr(3, 8'h00);
      end
      for (i = 0; i < 2; i++) begin
         cfg(8'h06, {hs[i], 8'h00});
         run(600, 16'h0, 1);
         run(512, 16'h0, 0);
         chk(tg[15:0], hs[i] ? 16'd512 / hs[i] : 16'h2);
      end
      for (i = 0; i < 3; i++) begin
         cfg(8'h02, {hs[i], hs[i]});
         run(256, 16'h0, 0);
         run(256, 16'h0, 0);
         chk(hi[15:0], 16'h100 - hs[i]);
      end
      wr(1, 8'h40);
      run(256, 16'h0, 0);
      chk(hi[15:0], 16'h0);
      cfg(8'h8b, 16'hfff8);
      expQ.push_back(16'hfff8);
      run(16, 16'hfff0, 1);
      chk(hi[15:0], 16'h8);
      chk({15'h0, eventIrq}, 16'h1);
      wr(3, 8'h00);
      cfg(8'h82, 16'hffff);
      run(16, 16'hfff0, 1);
      chk(hi[15:0], 16'h1);
      chk(expQ.size(), 16'h0);
      end_sim();
   end
endmodule // tb_top
